// ===== rxpd_pkg.sv
// Purpose: Shared constants, types and helpers of the receive test pattern detector
// Assumes: One receive framer channel, 8-bit register port
// Notes: Pattern codes follow the 4-bit select field of the control register
package rxpd_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] RXPD_OFS_CTRL = 8'h00;
  localparam logic [7:0] RXPD_OFS_STATUS = 8'h01;
  localparam logic [7:0] RXPD_OFS_ERRCNT = 8'h02;
  localparam logic [7:0] RXPD_OFS_IRQ_STAT = 8'h03;
  localparam logic [7:0] RXPD_OFS_IRQ_MASK = 8'h04;

  // Reset values
  localparam logic [7:0] RXPD_CTRL_RST = 8'h00;
  localparam logic [7:0] RXPD_MASK_RST = 8'h00;

  // Control register fields
  localparam int RXPD_CTRL_ENABLE_BIT = 0;
  localparam int RXPD_CTRL_BLKSEL_BIT = 2;
  localparam int RXPD_CTRL_UNFRAMED_BIT = 3;
  localparam int RXPD_CTRL_PAT_LSB = 4;

  // Detector status fields
  localparam int RXPD_STAT_LOCKED_BIT = 0;
  localparam int RXPD_STAT_ERR_BIT = 1;
  localparam int RXPD_STAT_SEARCH_BIT = 2;

  // Interrupt status and mask fields
  localparam int RXPD_IRQ_LOCK_BIT = 0;
  localparam int RXPD_IRQ_ERR_BIT = 1;
  localparam int RXPD_IRQ_W = 2;

  // Search and check history
  localparam int RXPD_HIST_W = 23;
  localparam int RXPD_QRSS_ZERO_RUN = 14;
  localparam logic [5:0] RXPD_LOCK_MATCHES = 6'h20;
  localparam logic [7:0] RXPD_ERRCNT_MAX = 8'hFF;

  typedef enum logic [3:0] {
    RXPD_PAT_MARK = 4'b0000,
    RXPD_PAT_QRSS = 4'b0001,
    RXPD_PAT_P5 = 4'b0010,
    RXPD_PAT_P6 = 4'b0011,
    RXPD_PAT_P9A = 4'b0100,
    RXPD_PAT_P9B = 4'b0101,
    RXPD_PAT_P11 = 4'b0110,
    RXPD_PAT_P11R = 4'b0111,
    RXPD_PAT_P15 = 4'b1000,
    RXPD_PAT_P20A = 4'b1001,
    RXPD_PAT_P20B = 4'b1010,
    RXPD_PAT_P23 = 4'b1011,
    RXPD_PAT_ALT = 4'b1100
  } rxpd_pat_t;

  typedef enum logic [1:0] {
    RXPD_ST_IDLE = 2'b00,
    RXPD_ST_SEARCH = 2'b01,
    RXPD_ST_LOCKED = 2'b10
  } rxpd_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rxpd_bus_req_t;

  typedef struct packed {
    logic bit_en;
    logic data;
    logic overhead;
  } rxpd_rx_t;

  typedef struct packed {
    logic [4:0] a;
    logic [4:0] b;
  } rxpd_taps_t;

  // Codes above the alternating pattern select nothing
  function automatic logic rxpd_code_valid(input logic [3:0] code);
    rxpd_code_valid = (code <= RXPD_PAT_ALT);
  endfunction : rxpd_code_valid

  // Feedback taps of the selected sequence, one-based history positions
  function automatic rxpd_taps_t rxpd_taps(input logic [3:0] code);
    rxpd_taps_t t;
    t = '{a: 5'h01, b: 5'h01};
    case (code)
      RXPD_PAT_QRSS: t = '{a: 5'h11, b: 5'h14};
      RXPD_PAT_P5: t = '{a: 5'h03, b: 5'h05};
      RXPD_PAT_P6: t = '{a: 5'h01, b: 5'h06};
      RXPD_PAT_P9A: t = '{a: 5'h05, b: 5'h09};
      RXPD_PAT_P9B: t = '{a: 5'h04, b: 5'h09};
      RXPD_PAT_P11: t = '{a: 5'h09, b: 5'h0B};
      RXPD_PAT_P11R: t = '{a: 5'h02, b: 5'h0B};
      RXPD_PAT_P15: t = '{a: 5'h0E, b: 5'h0F};
      RXPD_PAT_P20A: t = '{a: 5'h03, b: 5'h14};
      RXPD_PAT_P20B: t = '{a: 5'h11, b: 5'h14};
      RXPD_PAT_P23: t = '{a: 5'h12, b: 5'h17};
      default: t = '{a: 5'h01, b: 5'h01};
    endcase
    rxpd_taps = t;
  endfunction : rxpd_taps

endpackage : rxpd_pkg

// ===== rxpd_expect.sv
// Purpose: Expected next bit of the selected test pattern
// Assumes: History bit 0 is the newest bit
// Notes: Purely combinational; the caller owns the history
`timescale 1ns/10ps
module rxpd_expect (
  input wire logic [3:0] code,
  input wire logic [rxpd_pkg::RXPD_HIST_W-1:0] hist,
  output logic gen_bit,
  output logic exp_bit
);

  rxpd_pkg::rxpd_taps_t taps;
  logic zero_run;

  always_comb
  begin
    taps = rxpd_pkg::rxpd_taps(code);
    zero_run = (hist[rxpd_pkg::RXPD_QRSS_ZERO_RUN-1:0] == '0);
    unique case (code)
      rxpd_pkg::RXPD_PAT_MARK: gen_bit = 1'b1; // see R11
      rxpd_pkg::RXPD_PAT_ALT: gen_bit = ~hist[0]; // see R14
      default: gen_bit = hist[taps.a - 5'h01] ^ hist[taps.b - 5'h01]; // see R12 see R13 see R14
    endcase
    // Zero suppression forces a one after a long run of zeros
    if (code == rxpd_pkg::RXPD_PAT_QRSS && zero_run)
    begin
      exp_bit = 1'b1; // see R11
    end
    else
    begin
      exp_bit = gen_bit;
    end
  end

endmodule : rxpd_expect

// ===== rxpd_irq.sv
// Purpose: Sticky event bits, mask and level interrupt of the detector
// Assumes: A read of the status register clears it
// Notes: An event in the clearing cycle stays set
`timescale 1ns/10ps
module rxpd_irq (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [rxpd_pkg::RXPD_IRQ_W-1:0] events,
  input wire logic [rxpd_pkg::RXPD_IRQ_W-1:0] mask,
  input wire logic clear,
  output logic [rxpd_pkg::RXPD_IRQ_W-1:0] status,
  output logic irq
);

  typedef struct packed {
    logic [rxpd_pkg::RXPD_IRQ_W-1:0] stat;
  } rxpd_irq_st_t;

  rxpd_irq_st_t s_q;
  rxpd_irq_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (clear)
    begin
      s_d.stat = '0;
    end
    s_d.stat = s_d.stat | events;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign status = s_q.stat;
  assign irq = |(s_q.stat & mask);

  a_irq_set_wins: assert property (@(posedge clock) disable iff (sys_rst)
    (events != '0) |=> ((status & $past(events)) == $past(events)))
    else $error("event lost in interrupt status");

endmodule : rxpd_irq

// ===== rxpd_detector.sv
// Purpose: Receive test pattern detector of one framer channel
// Assumes: One received bit per cycle with bit_en high; overhead flags framing bits
// Notes: Registers on a plain port, read data one cycle after the read strobe
//
// Operation
// R1 - Control register resets to zero; detector idle, no pattern chosen.
// R2 - Software writes zero to control before choosing or changing a pattern.
// R3 - Writing zero to control clears the detector status.
// R4 - Once the pattern is found, stay locked to that alignment.
// R5 - While locked, every mismatching received bit counts as a bit error.
// R6 - Realignment happens only after control is written with zero.
// R7 - Bit 0 enables searching the received data for the chosen pattern.
// R8 - Bit 2 selects this detector block; bit 1 is reserved, written zero.
// R9 - Bit 3 set checks every bit; clear skips framing overhead bits.
// R10 - Bits 4 to 7 choose the expected fixed or random pattern.
// R11 - Code zero is all ones; code one is QRSS from taps 17/20.
// R12 - Short random sequences with taps 3/5, 1/6, 5/9 and 4/9.
// R13 - 2047-bit sequence with taps 9/11 and its reversed variant.
// R14 - Sequences 2^15-1, 2^20-1 twice, 2^23-1, and one-zero alternation.
// R15 - Software sets the test routing control to zero before pattern work.
// R16 - One bit per cycle against a local generator seeded during search.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
module rxpd_detector (
  input wire logic clock,
  input wire logic sys_rst,
  input wire rxpd_pkg::rxpd_bus_req_t bus,
  output logic [7:0] rd_data,
  input wire rxpd_pkg::rxpd_rx_t rx,
  output logic irq,
  output logic pattern_locked
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [rxpd_pkg::RXPD_IRQ_W-1:0] mask;
    rxpd_pkg::rxpd_state_t state;
    logic [rxpd_pkg::RXPD_HIST_W-1:0] hist;
    logic [5:0] match_cnt;
    logic err_seen;
    logic [7:0] err_cnt;
    logic [7:0] rd_data;
  } rxpd_main_st_t;

  rxpd_main_st_t s_q;
  rxpd_main_st_t s_d;

  logic ctrl_wr;
  logic clr_wr;
  logic irq_rd;
  logic [3:0] pat_code;
  logic det_enable;
  logic unframed;
  logic take_bit;
  logic exp_bit;
  logic bit_match;
  logic lock_ev;
  logic err_ev;
  logic [rxpd_pkg::RXPD_IRQ_W-1:0] irq_events;
  logic [rxpd_pkg::RXPD_IRQ_W-1:0] irq_status;
  logic [7:0] status_word;

  assign ctrl_wr = bus.wr && (bus.addr == rxpd_pkg::RXPD_OFS_CTRL);
  assign clr_wr = ctrl_wr && (bus.wdata == 8'h00); // see R3 see R6
  assign irq_rd = bus.rd && (bus.addr == rxpd_pkg::RXPD_OFS_IRQ_STAT);

  assign pat_code = s_q.ctrl[rxpd_pkg::RXPD_CTRL_PAT_LSB +: 4]; // see R10
  assign unframed = s_q.ctrl[rxpd_pkg::RXPD_CTRL_UNFRAMED_BIT];
  // Both enable and block select are needed; unknown codes never search
  assign det_enable = s_q.ctrl[rxpd_pkg::RXPD_CTRL_ENABLE_BIT]
                    && s_q.ctrl[rxpd_pkg::RXPD_CTRL_BLKSEL_BIT]
                    && rxpd_pkg::rxpd_code_valid(pat_code); // see R7 see R8
  // Framed mode leaves overhead bits out of both search and check
  assign take_bit = rx.bit_en && (unframed || !rx.overhead); // see R9

  rxpd_expect u_expect ( // see R10 see R12 see R13 see R14
    .code(pat_code),
    .hist(s_q.hist),
    .gen_bit(),
    .exp_bit(exp_bit)
  );

  assign bit_match = (rx.data == exp_bit);

  always_comb
  begin
    s_d = s_q;
    lock_ev = 1'b0;
    err_ev = 1'b0;

    unique case (s_q.state)
      rxpd_pkg::RXPD_ST_IDLE:
      begin
        if (det_enable)
        begin
          s_d.state = rxpd_pkg::RXPD_ST_SEARCH; // see R7
          s_d.match_cnt = '0;
        end
      end
      rxpd_pkg::RXPD_ST_SEARCH:
      begin
        if (!det_enable)
        begin
          s_d.state = rxpd_pkg::RXPD_ST_IDLE;
        end
        else if (take_bit)
        begin
          // Seed the local generator from the line itself
          s_d.hist = {s_q.hist[rxpd_pkg::RXPD_HIST_W-2:0], rx.data}; // see R16
          if (!bit_match)
          begin
            s_d.match_cnt = '0;
          end
          else if (s_q.match_cnt == rxpd_pkg::RXPD_LOCK_MATCHES - 6'h01)
          begin
            s_d.state = rxpd_pkg::RXPD_ST_LOCKED; // see R16
            lock_ev = 1'b1;
          end
          else
          begin
            s_d.match_cnt = s_q.match_cnt + 6'h01;
          end
        end
      end
      rxpd_pkg::RXPD_ST_LOCKED:
      begin
        // Lock holds until control is cleared; no loss-of-lock search
        if (det_enable && take_bit) // see R4
        begin
          // Expected bit, so forced ones match the history built in search
          s_d.hist = {s_q.hist[rxpd_pkg::RXPD_HIST_W-2:0], exp_bit}; // see R16
          if (!bit_match)
          begin
            err_ev = 1'b1; // see R5
          end
        end
      end
    endcase

    if (err_ev)
    begin
      s_d.err_seen = 1'b1; // see R5
      if (s_q.err_cnt != rxpd_pkg::RXPD_ERRCNT_MAX)
      begin
        s_d.err_cnt = s_q.err_cnt + 8'h01;
      end
    end

    if (ctrl_wr)
    begin
      s_d.ctrl = bus.wdata;
    end
    if (clr_wr)
    begin
      // Only path from lock back to search; status cleared with it
      s_d.state = rxpd_pkg::RXPD_ST_IDLE; // see R6
      s_d.hist = '0;
      s_d.match_cnt = '0;
      s_d.err_seen = 1'b0; // see R3
      s_d.err_cnt = 8'h00; // see R3
    end
    if (bus.wr && bus.addr == rxpd_pkg::RXPD_OFS_IRQ_MASK)
    begin
      s_d.mask = bus.wdata[rxpd_pkg::RXPD_IRQ_W-1:0];
    end

    if (bus.rd)
    begin
      unique case (bus.addr)
        rxpd_pkg::RXPD_OFS_CTRL: s_d.rd_data = s_q.ctrl;
        rxpd_pkg::RXPD_OFS_STATUS: s_d.rd_data = status_word;
        rxpd_pkg::RXPD_OFS_ERRCNT: s_d.rd_data = s_q.err_cnt;
        rxpd_pkg::RXPD_OFS_IRQ_STAT: s_d.rd_data = {6'h00, irq_status};
        rxpd_pkg::RXPD_OFS_IRQ_MASK: s_d.rd_data = {6'h00, s_q.mask};
        default: s_d.rd_data = 8'h00;
      endcase
    end
    else
    begin
      s_d.rd_data = 8'h00;
    end
  end

  always_comb
  begin
    status_word = 8'h00;
    status_word[rxpd_pkg::RXPD_STAT_LOCKED_BIT] = (s_q.state == rxpd_pkg::RXPD_ST_LOCKED);
    status_word[rxpd_pkg::RXPD_STAT_ERR_BIT] = s_q.err_seen;
    status_word[rxpd_pkg::RXPD_STAT_SEARCH_BIT] = (s_q.state == rxpd_pkg::RXPD_ST_SEARCH);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_q.ctrl <= rxpd_pkg::RXPD_CTRL_RST; // see R1
      s_q.mask <= rxpd_pkg::RXPD_MASK_RST[rxpd_pkg::RXPD_IRQ_W-1:0];
      s_q.state <= rxpd_pkg::RXPD_ST_IDLE;
      s_q.hist <= '0;
      s_q.match_cnt <= '0;
      s_q.err_seen <= 1'b0;
      s_q.err_cnt <= 8'h00;
      s_q.rd_data <= 8'h00;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_comb
  begin
    irq_events = '0;
    irq_events[rxpd_pkg::RXPD_IRQ_LOCK_BIT] = lock_ev;
    irq_events[rxpd_pkg::RXPD_IRQ_ERR_BIT] = err_ev;
  end

  rxpd_irq u_irq (
    .clock(clock),
    .sys_rst(sys_rst),
    .events(irq_events),
    .mask(s_q.mask),
    .clear(irq_rd),
    .status(irq_status),
    .irq(irq)
  );

  assign rd_data = s_q.rd_data;
  assign pattern_locked = (s_q.state == rxpd_pkg::RXPD_ST_LOCKED);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_clear_write;
    clr_wr;
  endsequence

  sequence s_locked_bit_err;
    (s_q.state == rxpd_pkg::RXPD_ST_LOCKED) && det_enable && take_bit && !bit_match;
  endsequence

  a_reset_ctrl_zero: assert property (disable iff (1'b0) // see R1
    sys_rst |=> (s_q.ctrl == 8'h00 && s_q.state == rxpd_pkg::RXPD_ST_IDLE))
    else $error("control not zero after reset");

  a_zero_clears_status: assert property (s_clear_write |=> // see R3
    (status_word == 8'h00 && s_q.err_cnt == 8'h00))
    else $error("zero write left detector status");

  a_lock_holds_on: assert property ( // see R4
    (s_q.state == rxpd_pkg::RXPD_ST_LOCKED) && !clr_wr |=> pattern_locked)
    else $error("lock dropped without clearing write");

  a_mismatch_is_error: assert property (s_locked_bit_err |=> // see R5
    (irq_status[rxpd_pkg::RXPD_IRQ_ERR_BIT] && (s_q.err_seen || $past(clr_wr))))
    else $error("mismatch while locked not reported");

  a_search_from_idle: assert property ( // see R6
    $rose(s_q.state == rxpd_pkg::RXPD_ST_SEARCH) |->
    $past(s_q.state) == rxpd_pkg::RXPD_ST_IDLE)
    else $error("search entered without passing idle");

  a_search_needs_enable: assert property ( // see R7
    (s_q.state == rxpd_pkg::RXPD_ST_SEARCH) && !$past(clr_wr) |->
    $past(s_q.ctrl[rxpd_pkg::RXPD_CTRL_ENABLE_BIT]))
    else $error("search without enable bit");

  a_blksel_gates_search: assert property ( // see R8
    (s_q.state == rxpd_pkg::RXPD_ST_IDLE) && !s_q.ctrl[rxpd_pkg::RXPD_CTRL_BLKSEL_BIT]
    && !ctrl_wr |=> (s_q.state == rxpd_pkg::RXPD_ST_IDLE))
    else $error("search started without block select");

  a_framed_skips_ovh: assert property ( // see R9
    rx.bit_en && rx.overhead && !unframed && !clr_wr |=> $stable(s_q.hist))
    else $error("overhead bit used in framed mode");

  a_lock_after_matches: assert property ( // see R16
    (s_q.state == rxpd_pkg::RXPD_ST_SEARCH) && det_enable && take_bit && bit_match
    && (s_q.match_cnt == rxpd_pkg::RXPD_LOCK_MATCHES - 6'h01) && !clr_wr
    |=> pattern_locked ##0 irq_status[rxpd_pkg::RXPD_IRQ_LOCK_BIT])
    else $error("no lock after full match run");

  a_mark_expects_one: assert property ( // see R11
    (pat_code == rxpd_pkg::RXPD_PAT_MARK) |-> exp_bit)
    else $error("all-ones pattern does not expect one");

  a_read_data_slot: assert property ( // see R10
    bus.rd && bus.addr == rxpd_pkg::RXPD_OFS_CTRL && !$past(ctrl_wr) |=>
    rd_data == $past(s_q.ctrl))
    else $error("control readback wrong");

endmodule : rxpd_detector

// ===== rxpd_rx_model.sv
// Purpose: Behavioural receive framer data path that sends line test patterns
// Assumes: One bit per cycle, or one bit every third cycle when slow is high
// Notes: Overhead bits carry the inverse of the pattern bit; inject flips one payload bit
`timescale 1ns/10ps
module rxpd_rx_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] code,
  input wire logic framed,
  input wire logic slow,
  input wire logic inject,
  output rxpd_pkg::rxpd_rx_t rx
);
  logic [22:0] hist_q;
  logic [3:0] code_q;
  logic [2:0] cnt_q;
  logic [1:0] pace_q;
  logic [9:0] tp;
  logic nxt;
  logic ovh;

  always_comb
  begin
    case (code)
      4'h1: tp = {5'h11, 5'h14};
      4'h2: tp = {5'h03, 5'h05};
      4'h3: tp = {5'h01, 5'h06};
      4'h4: tp = {5'h05, 5'h09};
      4'h5: tp = {5'h04, 5'h09};
      4'h6: tp = {5'h09, 5'h0B};
      4'h7: tp = {5'h02, 5'h0B};
      4'h8: tp = {5'h0E, 5'h0F};
      4'h9: tp = {5'h03, 5'h14};
      4'hA: tp = {5'h11, 5'h14};
      4'hB: tp = {5'h12, 5'h17};
      default: tp = {5'h01, 5'h01};
    endcase
    nxt = hist_q[tp[9:5] - 5'h01] ^ hist_q[tp[4:0] - 5'h01];
    if (code == 4'h0)
      nxt = 1'b1;
    if (code == 4'hC)
      nxt = ~hist_q[0];
    if (code == 4'h1 && hist_q[13:0] == 14'h0)
      nxt = 1'b1;
    ovh = framed && cnt_q == 3'h7;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || code != code_q)
    begin
      // Fresh seed, so no all-zero history carries into a new pattern
      hist_q <= '1;
      code_q <= code;
      cnt_q <= 3'h0;
      pace_q <= 2'h0;
      rx <= '0;
    end
    else
    begin
      pace_q <= (slow && pace_q != 2'h2) ? pace_q + 2'h1 : 2'h0;
      rx.bit_en <= pace_q == 2'h0;
      rx.overhead <= ovh && pace_q == 2'h0;
      if (pace_q == 2'h0)
      begin
        cnt_q <= cnt_q + 3'h1;
        rx.data <= ovh ? ~nxt : nxt ^ inject;
        if (!ovh)
          hist_q <= {hist_q[21:0], nxt};
      end
      else
        rx.data <= ~rx.data;
    end
  end
endmodule : rxpd_rx_model

// ===== rxpd_detector_test.sv
// Purpose: Self-checking bench of the receive test pattern detector
// Assumes: Register port with read data in the cycle after the strobe
// Notes: Every pattern code is locked at least once; errors injected on the all-ones pattern
`timescale 1ns/10ps
module rxpd_detector_test;
  logic clock;
  logic sys_rst;
  rxpd_pkg::rxpd_bus_req_t bus;
  logic [7:0] rd_data;
  rxpd_pkg::rxpd_rx_t rx;
  logic irq;
  logic pattern_locked;
  logic [3:0] code;
  logic framed;
  logic slow;
  logic inject;
  logic [7:0] v;
  int miscompares;
  int checked;

  rxpd_detector i_dut (.clock(clock), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data),
    .rx(rx), .irq(irq), .pattern_locked(pattern_locked));
  rxpd_rx_model i_src (.clock(clock), .sys_rst(sys_rst), .code(code), .framed(framed),
    .slow(slow), .inject(inject), .rx(rx));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task end_sim;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr

  task rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    v = rd_data;
    if (name != "")
      chk(name, v, exp);
  endtask : rdchk

  task wait_lock;
    int n;
    n = 0;
    while (pattern_locked !== 1'b1 && n < 4000)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 4000)
    begin
      miscompares++;
      $display("Error lock wait ran out");
      end_sim();
    end
  endtask : wait_lock

  task chk_pin(input string name, input logic pick_lock, input logic exp);
    @(posedge clock);
    #1;
    // Pin read here, not at the call, so the settled value is checked
    chk(name, {7'h00, (pick_lock ? pattern_locked : irq)}, {7'h00, exp});
  endtask : chk_pin

  initial
  begin
    sys_rst = 1'b1;
    bus = '0;
    code = 4'h0;
    framed = 1'b0;
    slow = 1'b0;
    inject = 1'b0;
    miscompares = 0;
    checked = 0;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++)
      rdchk("reset value", 8'(i), 8'h00);
    wr(8'h1F, 8'hFF);
    wr(rxpd_pkg::RXPD_OFS_STATUS, 8'hFF);
    rdchk("unmapped", 8'h1F, 8'h00);
    rdchk("status ro", rxpd_pkg::RXPD_OFS_STATUS, 8'h00);
    wr(rxpd_pkg::RXPD_OFS_IRQ_MASK, 8'h03);
    rdchk("mask", rxpd_pkg::RXPD_OFS_IRQ_MASK, 8'h03);
    for (int c = 0; c < 13; c++)
    begin
      wr(8'h00, 8'h00);
      code <= 4'(c);
      wr(8'h00, {4'(c), 4'hD});
      wait_lock();
      rdchk("lock status", 8'h01, 8'h01);
      chk_pin("irq lock", 1'b0, 1'b1);
      rdchk("irq status", 8'h03, 8'h01);
      chk_pin("irq cleared", 1'b0, 1'b0);
      rdchk("err count", 8'h02, 8'h00);
    end
    wr(8'h00, 8'h00);
    code <= 4'h0;
    wr(8'h00, 8'h0D);
    wait_lock();
    rdchk("", 8'h03, 8'h00);
    repeat (3)
    begin
      @(posedge clock);
      inject <= 1'b1;
      @(posedge clock);
      inject <= 1'b0;
      repeat (4) @(posedge clock);
    end
    rdchk("err count", 8'h02, 8'h03);
    rdchk("err status", 8'h01, 8'h03);
    chk_pin("irq err", 1'b0, 1'b1);
    rdchk("irq err", 8'h03, 8'h02);
    // Data now differs on every other bit; the lock has to hold anyway
    code <= 4'hC;
    // Long enough for the error count to reach its ceiling
    repeat (600) @(posedge clock);
    chk_pin("held lock", 1'b1, 1'b1);
    rdchk("saturated count", 8'h02, 8'hFF);
    wr(8'h00, 8'h00);
    rdchk("cleared status", 8'h01, 8'h00);
    rdchk("cleared count", 8'h02, 8'h00);
    chk_pin("unlocked", 1'b1, 1'b0);
    rdchk("", 8'h03, 8'h00);
    code <= 4'h0;
    wr(8'h00, 8'h09);
    repeat (100) @(posedge clock);
    rdchk("no block", 8'h01, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h0C);
    repeat (100) @(posedge clock);
    rdchk("no enable", 8'h01, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h00, 8'hDD);
    repeat (100) @(posedge clock);
    rdchk("no code", 8'h01, 8'h00);
    wr(8'h00, 8'h00);
    wr(rxpd_pkg::RXPD_OFS_IRQ_MASK, 8'h00);
    framed <= 1'b1;
    slow <= 1'b1;
    wr(8'h00, 8'h05);
    wait_lock();
    repeat (100) @(posedge clock);
    rdchk("framed count", 8'h02, 8'h00);
    chk_pin("masked irq", 1'b0, 1'b0);
    rdchk("masked status", 8'h03, 8'h01);
    end_sim();
  end
endmodule : rxpd_detector_test
